// file: rtl/atc_angle_counter.sv
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ps
`include "atc_params.svh"
// Behaviour
// - tooth program holds ticks, missing, last, insert
// - tick period from 15-bit rate and prescaler
// - first normal tick, no tooth: stay normal
// - early tooth in normal: high rate, clear
// - normal decrements missing; halt only at zero
// - tooth in normal with last set clears last, insert, base
// - new ticks apply after halt tooth; base from 0
// - zero ticks with small period is unsupported
module atc_angle_counter
   import atc_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_tooth,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [1:0] o_mode,
   output logic [23:0] o_angle_count,
   output logic o_angle_tick,
   output logic o_cfg_unsupported
);
   // microcycle strobe
   logic [`ATC_UC_W-1:0] uc_cnt_q;
   wire uc_w = (uc_cnt_q == `ATC_UC_W'(`ATC_UC_CYC - 1));

   // bus slave state
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic hreadyout_q;
   logic hresp_q;

   // block state
   atc_mode_t mode_q, mode_d;
   logic [7:0] ticks_prog_q, ticks_act_q, ticks_act_d, ticks_cnt_q, ticks_cnt_d;
   logic [7:0] miss_q, miss_hw_d, miss_d;
   logic last_q, last_hw_d, last_d;
   logic ins_q, ins_hw_d, ins_d;
   logic [23:0] angle_q, angle_d, tb2_q, tb2_d;
   logic [`ATC_TR_W-1:0] rate_q;
   logic [7:0] presc_q;
   logic tooth_q, tooth_pend_q, tick_q, unsup_q;
   logic tick_w;

   // address phase and write decode
   wire addr_ok_w = i_hsel && i_htrans[1] && i_hready;
   wire [7:0] ra_w = i_haddr[7:0];
   wire wr_tp_w = wr_pend_q && (wr_addr_q == `ATC_OFS_TOOTH_PROG);
   wire wr_tr_w = wr_pend_q && (wr_addr_q == `ATC_OFS_TICK_RATE);
   wire wr_tb_w = wr_pend_q && (wr_addr_q == `ATC_OFS_TB_CFG);
   wire ins_wr_w = wr_tp_w && i_hwdata[`ATC_TP_INS_BIT];

   // integer part of the rate; zero is not a legal period, treat as one
   wire [14:0] rate_int_raw_w = rate_q[`ATC_TR_INT_LSB +: 15];
   wire [14:0] rate_int_w = (rate_int_raw_w == 15'h0000) ? 15'h0001 : rate_int_raw_w;
   wire [23:0] prod_w = 24'(rate_int_w - 15'h0001) * (24'(presc_q) + 24'h000001);
   wire unsup_d_w = (ticks_prog_q == 8'h00) && (prod_w < `ATC_SAFE_PROD);

   // physical or dummy tooth, held until the next microcycle
   wire tooth_edge_w = i_tooth && !tooth_q;
   wire tooth_ev_w = tooth_pend_q && uc_w;
   wire overdue_w = (ticks_cnt_q >= ticks_act_q);

   wire [31:0] tp_rd_w = {14'h0000, ins_q, last_q, miss_q, ticks_prog_q};
   wire [31:0] st_rd_w = {29'h00000000, unsup_q, mode_q};
   wire [31:0] rd_mux_w =
      (ra_w == `ATC_OFS_TOOTH_PROG) ? tp_rd_w :
      (ra_w == `ATC_OFS_TICK_RATE) ? {8'h00, rate_q} :
      (ra_w == `ATC_OFS_TB_CFG) ? {24'h000000, presc_q} :
      (ra_w == `ATC_OFS_STATUS) ? st_rd_w :
      (ra_w == `ATC_OFS_ANGLE) ? {8'h00, angle_q} :
      (ra_w == `ATC_OFS_TB2) ? {8'h00, tb2_q} : 32'h00000000;

   atc_tick_gen u_tick_gen (
      .i_clk_sys(i_clk_sys),
      .i_sys_rst(i_sys_rst),
      .i_uc(uc_w),
      .i_rate_int(rate_int_w),
      .i_presc(presc_q),
      .o_tick(tick_w)
   );

   always_comb begin
      mode_d = mode_q;
      ticks_act_d = ticks_act_q;
      ticks_cnt_d = ticks_cnt_q;
      miss_hw_d = miss_q;
      last_hw_d = last_q;
      ins_hw_d = ins_q && !tooth_ev_w;
      angle_d = angle_q;
      tb2_d = tb2_q;
      if (uc_w) begin
         unique case (mode_q)
            ATC_HIGH_RATE: begin
               ticks_act_d = ticks_prog_q;
               if (!overdue_w) begin
                  ticks_cnt_d = ticks_cnt_q + 8'h01;
                  angle_d = angle_q + 24'h000001;
                  tb2_d = tb2_q + 24'h000001;
               end else begin
                  mode_d = ATC_NORMAL;
                  ticks_cnt_d = 8'h00;
               end
            end
            ATC_NORMAL: begin
               if (tooth_pend_q) begin
                  if (last_q) begin
                     last_hw_d = 1'b0;
                     ins_hw_d = 1'b0;
                     tb2_d = 24'h000000;
                  end
                  if (!overdue_w) begin
                     mode_d = ATC_HIGH_RATE;
                     miss_hw_d = 8'h00;
                     last_hw_d = 1'b0;
                  end else begin
                     ticks_cnt_d = 8'h00;
                  end
               end else if (overdue_w) begin
                  // halt decided on the current value, not the decremented one
                  if (miss_q == 8'h00) begin
                     mode_d = ATC_HALT;
                  end else begin
                     miss_hw_d = miss_q - 8'h01;
                  end
               end else if (tick_w) begin
                  ticks_cnt_d = ticks_cnt_q + 8'h01;
                  angle_d = angle_q + 24'h000001;
                  tb2_d = tb2_q + 24'h000001;
               end
            end
            ATC_HALT: begin
               if (tooth_pend_q) begin
                  mode_d = ATC_NORMAL;
                  ticks_act_d = ticks_prog_q;
                  ticks_cnt_d = 8'h00;
                  tb2_d = 24'h000000;
               end
            end
            default: mode_d = ATC_HALT;
         endcase
      end
   end

   // software write to the program register overrides the hardware update of missing and last; an insert write can only set
   assign miss_d = wr_tp_w ? i_hwdata[`ATC_TP_MISS_LSB +: 8] : miss_hw_d;
   assign last_d = wr_tp_w ? i_hwdata[`ATC_TP_LAST_BIT] : last_hw_d;
   assign ins_d = ins_wr_w || ins_hw_d; // set wins over clear

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         uc_cnt_q <= '0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h00000000;
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end else begin
         uc_cnt_q <= uc_w ? '0 : uc_cnt_q + `ATC_UC_W'(1);
         wr_pend_q <= addr_ok_w && i_hwrite;
         wr_addr_q <= ra_w;
         // read data fetched in the address phase; a read right after a write sees old data
         hrdata_q <= (addr_ok_w && !i_hwrite) ? rd_mux_w : 32'h00000000;
         // zero wait states and every access answered okay
         hreadyout_q <= 1'b1;
         hresp_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         mode_q <= ATC_HIGH_RATE;
         ticks_prog_q <= `ATC_RST_TICKS;
         ticks_act_q <= `ATC_RST_TICKS;
         ticks_cnt_q <= 8'h00;
         miss_q <= `ATC_RST_MISS;
         last_q <= 1'b0;
         ins_q <= 1'b0;
         angle_q <= 24'h000000;
         tb2_q <= 24'h000000;
         rate_q <= `ATC_RST_RATE;
         presc_q <= `ATC_RST_PRESC;
         tooth_q <= 1'b0;
         tooth_pend_q <= 1'b0;
         tick_q <= 1'b0;
         unsup_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         ticks_act_q <= ticks_act_d;
         ticks_cnt_q <= ticks_cnt_d;
         miss_q <= miss_d;
         last_q <= last_d;
         ins_q <= ins_d;
         angle_q <= angle_d;
         tb2_q <= tb2_d;
         tooth_q <= i_tooth;
         tooth_pend_q <= tooth_edge_w || ins_wr_w || (tooth_pend_q && !uc_w);
         tick_q <= tick_w;
         unsup_q <= unsup_d_w;
         if (wr_tp_w) begin
            ticks_prog_q <= i_hwdata[`ATC_TP_TICKS_LSB +: 8];
         end
         if (wr_tr_w) begin
            rate_q <= i_hwdata[`ATC_TR_W-1:0];
         end
         if (wr_tb_w) begin
            presc_q <= i_hwdata[7:0];
         end
      end
   end

   assign o_hrdata = hrdata_q;
   assign o_hreadyout = hreadyout_q;
   assign o_hresp = hresp_q;
   assign o_mode = mode_q;
   assign o_angle_count = angle_q;
   assign o_angle_tick = tick_q;
   assign o_cfg_unsupported = unsup_q;

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);

   halt_only_zero_a: assert property (
      mode_q == ATC_NORMAL ##1 mode_q == ATC_HALT |-> $past(miss_q) == 8'h00)
      else $error("halt entered with missing count above zero");
   miss_decrement_a: assert property (
      mode_q == ATC_NORMAL && uc_w && !tooth_pend_q && overdue_w && miss_q != 8'h00 && !wr_tp_w
      |=> miss_q == $past(miss_q) - 8'h01 && mode_q == ATC_NORMAL)
      else $error("missing count not decremented");
   stay_normal_a: assert property (
      mode_q == ATC_NORMAL && uc_w && tick_w && !tooth_pend_q && miss_q != 8'h00
      |=> mode_q == ATC_NORMAL)
      else $error("left normal on tick without tooth");
   early_tooth_a: assert property (
      mode_q == ATC_NORMAL && uc_w && tooth_pend_q && !overdue_w && !wr_tp_w
      |=> mode_q == ATC_HIGH_RATE && miss_q == 8'h00 && !last_q)
      else $error("early tooth not handled");
   last_clear_a: assert property (
      mode_q == ATC_NORMAL && uc_w && tooth_pend_q && last_q && !wr_tp_w
      |=> !last_q && !ins_q && tb2_q == 24'h000000)
      else $error("last tooth flags not cleared");
   halt_reload_a: assert property (
      mode_q == ATC_HALT && uc_w && tooth_pend_q
      |=> mode_q == ATC_NORMAL && tb2_q == 24'h000000 && ticks_act_q == $past(ticks_prog_q))
      else $error("halt tooth did not reload ticks");
   ticks_frozen_a: assert property (
      mode_q == ATC_NORMAL |=> ticks_act_q == $past(ticks_act_q))
      else $error("tick count changed in normal mode");
   dummy_tooth_a: assert property (
      ins_wr_w |=> tooth_pend_q ##[0:4] (tooth_pend_q && uc_w))
      else $error("dummy tooth not raised");
   unsup_flag_a: assert property (
      ticks_prog_q == 8'h00 && presc_q == 8'h00 && rate_int_w == 15'h0001 ##1 $stable(ticks_prog_q)
      |-> unsup_q)
      else $error("unsupported setup not flagged");

   unit_tick_a: assert property (
      uc_w && rate_int_w == 15'h0001 && presc_q == 8'h00
      |-> tick_w)
      else $error("unit period did not tick every microcycle");
   miss_uc_only_a: assert property (
      !uc_w && !wr_tp_w
      |=> miss_q == $past(miss_q))
      else $error("missing count moved between microcycles");
   halt_hold_a: assert property (
      mode_q == ATC_HALT && !(uc_w && tooth_pend_q)
      |=> mode_q == ATC_HALT)
      else $error("halt left without a tooth");
   halt_angle_a: assert property (
      mode_q == ATC_HALT
      |=> angle_q == $past(angle_q))
      else $error("angle moved in halt");
   tooth_no_halt_a: assert property (
      mode_q == ATC_NORMAL && uc_w && tooth_pend_q
      |=> mode_q != ATC_HALT)
      else $error("tooth in normal led to halt");
   insert_used_a: assert property (
      ins_q && uc_w && tooth_pend_q && !ins_wr_w
      |=> !ins_q)
      else $error("insert request not consumed by its tooth");
   base_step_a: assert property (
      tb2_q != $past(tb2_q)
      |-> tb2_q == $past(tb2_q) + 24'h000001 || tb2_q == 24'h000000)
      else $error("second time base jumped");
   // the first normal microcycle comes three clocks after the switch
   first_normal_a: assert property (
      mode_q == ATC_HIGH_RATE ##1 mode_q == ATC_NORMAL
      ##3 uc_w && tick_w && !tooth_pend_q && miss_q != 8'h00
      |=> mode_q == ATC_NORMAL)
      else $error("first normal microcycle left normal");

   halt_entry_c: cover property (mode_q == ATC_NORMAL ##1 mode_q == ATC_HALT);
   dummy_tooth_c: cover property (ins_wr_w);
   early_tooth_c: cover property (mode_q == ATC_NORMAL ##1 mode_q == ATC_HIGH_RATE);
   halt_exit_c: cover property (mode_q == ATC_HALT ##1 mode_q == ATC_NORMAL);
   unsup_cfg_c: cover property ($rose(unsup_q));
endmodule // atc_angle_counter

// file: rtl/atc_params.svh
`ifndef ATC_PARAMS_SVH
`define ATC_PARAMS_SVH

// clock and microcycle timing
`define ATC_CLK_NS 5
`define ATC_UC_NS 20
`define ATC_UC_CYC (`ATC_UC_NS / `ATC_CLK_NS)
`define ATC_UC_W 3

// register byte offsets
`define ATC_OFS_TOOTH_PROG 8'h00
`define ATC_OFS_TICK_RATE 8'h04
`define ATC_OFS_TB_CFG 8'h08
`define ATC_OFS_STATUS 8'h0c
`define ATC_OFS_ANGLE 8'h10
`define ATC_OFS_TB2 8'h14

// tooth program fields
`define ATC_TP_TICKS_LSB 0
`define ATC_TP_MISS_LSB 8
`define ATC_TP_LAST_BIT 16
`define ATC_TP_INS_BIT 17

// tick rate: 15-bit integer part above 9 fraction bits
`define ATC_TR_INT_LSB 9
`define ATC_TR_W 24

// status fields
`define ATC_ST_MODE_LSB 0
`define ATC_ST_UNSUP_BIT 2

// reset values
`define ATC_RST_TICKS 8'h10
`define ATC_RST_MISS 8'h00
`define ATC_RST_RATE 24'h000200
`define ATC_RST_PRESC 8'h00

// least safe product of (rate - 1) * (prescaler + 1)
`define ATC_SAFE_PROD 24'h000003

`endif

// file: rtl/atc_pkg.sv
package atc_pkg;
   typedef enum logic [1:0] {
      ATC_HIGH_RATE = 2'b00,
      ATC_NORMAL = 2'b01,
      ATC_HALT = 2'b10
   } atc_mode_t;
endpackage

// file: rtl/atc_tick_gen.sv
`timescale 1ns/1ps
module atc_tick_gen (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_uc,
   input wire logic [14:0] i_rate_int,
   input wire logic [7:0] i_presc,
   output logic o_tick
);
   logic [22:0] cnt_q;
   logic [22:0] cnt_d;
   wire [22:0] period_w = 23'(i_rate_int) * (23'(i_presc) + 23'h000001);
   wire at_end_w = (cnt_q >= period_w - 23'h000001);

   // ticks are only evaluated on a microcycle
   assign o_tick = i_uc && at_end_w;
   assign cnt_d = !i_uc ? cnt_q : (at_end_w ? 23'h000000 : cnt_q + 23'h000001);

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         cnt_q <= 23'h000000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   tick_on_uc_a: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
      o_tick |-> i_uc && cnt_q >= period_w - 23'h000001)
      else $error("tick outside a microcycle");
endmodule // atc_tick_gen

// file: test/atc_wheel.sv
`timescale 1ns/1ps
module atc_wheel (
   input wire logic i_clk_sys,
   input wire logic i_sys_rst,
   input wire logic i_fire,
   output logic o_tooth
);
   logic [1:0] hold_q;
   // tooth stays high two cycles, so only one rising edge reaches the counter
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         hold_q <= 2'h0;
      end else if (i_fire) begin
         hold_q <= 2'h2;
      end else if (hold_q != 2'h0) begin
         hold_q <= hold_q - 2'h1;
      end
   end
   assign o_tooth = (hold_q != 2'h0);
endmodule // atc_wheel

// file: test/testbench.sv
`timescale 1ns/1ps
`include "atc_params.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module testbench;
   import atc_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_sys_rst = 1'b1;
   logic i_hsel = 1'b0;
   logic i_hwrite = 1'b0;
   logic fire = 1'b0;
   logic [31:0] i_haddr = 32'h0;
   logic [31:0] i_hwdata = 32'h0;
   logic [31:0] rd;
   logic [31:0] seed = 32'h5f;
   logic [31:0] r;
   logic [1:0] i_htrans = 2'h0;
   logic [2:0] i_hsize = 3'h2;
   logic [7:0] t;
   logic [14:0] ri;
   logic [7:0] p;
   wire tooth;
   wire hrdy;
   wire [31:0] hrdata;
   wire [1:0] mode;
   wire hresp;
   wire [23:0] angle;
   wire atick;
   wire unsup;
   int n_tick;
   int n_fail = 0;
   int check_count = 0;

   atc_wheel wheel (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_fire(fire), .o_tooth(tooth));
   atc_angle_counter uut (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_tooth(tooth), .i_hsel(i_hsel),
      .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hsize(i_hsize), .i_hwdata(i_hwdata),
      .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp), .o_mode(mode),
      .o_angle_count(angle), .o_angle_tick(atick), .o_cfg_unsupported(unsup));

   initial begin
      forever #2.5 i_clk_sys = ~i_clk_sys;
   end

   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   function automatic logic [31:0] tp(input logic ins, input logic last, input logic [7:0] m, input logic [7:0] k);
      return {14'h0, ins, last, m, k};
   endfunction

   // a zero integer part behaves as one
   function automatic logic exp_unsup(input logic [7:0] k, input logic [14:0] n, input logic [7:0] q);
      logic [23:0] prod;
      prod = 24'((n == 15'h0 ? 15'h1 : n) - 15'h1) * 24'(q + 8'h1);
      return (k == 8'h0) && (prod < 24'h3);
   endfunction

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      i_hsel <= 1'b1;
      i_haddr <= {24'h0, a};
      i_htrans <= 2'h2;
      i_hwrite <= w;
      @(posedge i_clk_sys);
      while (hrdy !== 1'b1 && k < 50) begin
         @(posedge i_clk_sys);
         k++;
      end
      i_htrans <= 2'h0;
      i_hwdata <= d;
      @(posedge i_clk_sys);
      while (hrdy !== 1'b1 && k < 100) begin
         @(posedge i_clk_sys);
         k++;
      end
      rd = hrdata;
      `CHK({hrdy, hresp}, 2'b10)
   endtask

   task automatic wait_mode(input logic [1:0] m, input int lim);
      int k;
      k = 0;
      while (mode !== m && k < lim) begin
         @(posedge i_clk_sys);
         k++;
      end
      `CHK(mode, m)
   endtask

   task automatic hit();
      fire <= 1'b1;
      @(posedge i_clk_sys);
      fire <= 1'b0;
      repeat (3) @(posedge i_clk_sys);
   endtask

   task automatic close_out();
      if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge i_clk_sys);
      i_sys_rst <= 1'b0;
      @(posedge i_clk_sys);
      `CHK(mode, ATC_HIGH_RATE)
      `CHK({angle, atick, unsup}, 26'h0)
      bus(1'b0, `ATC_OFS_TOOTH_PROG, 32'h0);
      `CHK(rd, {24'h0, `ATC_RST_TICKS})
      bus(1'b0, `ATC_OFS_TICK_RATE, 32'h0);
      `CHK(rd, {8'h0, `ATC_RST_RATE})
      bus(1'b0, `ATC_OFS_TB_CFG, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b0, 8'h18, 32'h0);
      `CHK(rd, 32'h0)
      bus(1'b1, `ATC_OFS_TOOTH_PROG, tp(1'b0, 1'b0, 8'h03, 8'h04));
      wait_mode(ATC_NORMAL, 200);
      // unit period: the first normal microcycle is also a tick
      repeat (5) @(posedge i_clk_sys);
      `CHK(mode, ATC_NORMAL)
      wait_mode(ATC_HALT, 2000);
      bus(1'b0, `ATC_OFS_TOOTH_PROG, 32'h0);
      `CHK(rd[15:8], 8'h00)
      // long period keeps the next tooth early
      bus(1'b1, `ATC_OFS_TICK_RATE, 32'h800);
      bus(1'b1, `ATC_OFS_TOOTH_PROG, tp(1'b0, 1'b1, 8'h05, 8'h40));
      hit();
      wait_mode(ATC_NORMAL, 12);
      bus(1'b0, `ATC_OFS_TB2, 32'h0);
      `CHK(rd < 32'h8, 1'b1)
      hit();
      wait_mode(ATC_HIGH_RATE, 12);
      bus(1'b0, `ATC_OFS_TOOTH_PROG, 32'h0);
      `CHK(rd[17:8], 10'h0)
      // integer part 4, prescaler 0: one tick every four microcycles
      n_tick = 0;
      repeat (160) begin
         @(posedge i_clk_sys);
         if (atick === 1'b1) n_tick++;
      end
      `CHK(n_tick, 160 / (`ATC_UC_CYC * 4))
      wait_mode(ATC_NORMAL, 600);
      // a short tick count written in normal must not end the tooth early
      bus(1'b1, `ATC_OFS_TOOTH_PROG, tp(1'b0, 1'b0, 8'h00, 8'h02));
      repeat (100) @(posedge i_clk_sys);
      `CHK(mode, ATC_NORMAL)
      wait_mode(ATC_HALT, 3000);
      r = {8'h0, angle};
      repeat (8) @(posedge i_clk_sys);
      `CHK(angle, r[23:0])
      bus(1'b0, `ATC_OFS_ANGLE, 32'h0);
      `CHK(rd, r)
      bus(1'b1, `ATC_OFS_TOOTH_PROG, tp(1'b1, 1'b0, 8'h00, 8'h40));
      wait_mode(ATC_NORMAL, 12);
      bus(1'b0, `ATC_OFS_TOOTH_PROG, 32'h0);
      `CHK(rd[17], 1'b0)
      for (int i = 0; i < 18; i++) begin
         r = xs();
         t = (i < 2 || !r[2]) ? 8'h0 : r[7:0];
         ri = (i < 2) ? 15'(i + 3) : {11'h0, r[11:8]};
         p = (i < 2) ? 8'h0 : {6'h0, r[31:30]};
         bus(1'b1, `ATC_OFS_TOOTH_PROG, tp(1'b0, 1'b0, 8'h40, t));
         bus(1'b1, `ATC_OFS_TICK_RATE, {8'h0, ri, r[20:12]});
         bus(1'b1, `ATC_OFS_TB_CFG, {24'h0, p});
         // the flag settles one clock after the last setting lands
         @(posedge i_clk_sys);
         bus(1'b0, `ATC_OFS_STATUS, 32'h0);
         `CHK(rd[2], exp_unsup(t, ri, p))
         `CHK(unsup, exp_unsup(t, ri, p))
      end
      close_out();
   end

   initial begin
      repeat (20000) @(posedge i_clk_sys);
      n_fail++;
      close_out();
   end
endmodule // testbench
